// *** hw/esio_consts.vh ***
// What this block does
// - Auto function 2 drives port 319 in auto
// - Class 0: any running program means auto
// - Stop or open gate holds in-range outputs; OUT drives them while emergency runs
// - Stop or gate starts emergency program, ranged
// - Emergency program must command no motion
// - Type 0: program running or cancel cause
// - Type 1: cancel cause regardless of program
// - Type 2: error, cancel, during program execution
// - Type 3: error and cancel, regardless of program
// - Release action 3 issues software reset
// - Release action 4 clears pending error
// - Autorun in AUTO starts program after restart
// - Autorun in AUTO starts program after reset
// - Recovery 0 re-enables drive after release
// - Action 2 resumes after release and 021 edge if auto was on at the stop
// - Pause-cancel function 1 uses input 021
// - Input 017 held one second soft resets
// - Soft-reset function 1 uses input 017
`ifndef ESIO_CONSTS_VH
`define ESIO_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ESIO_OFF_CTRL 8'h00
`define ESIO_OFF_PROG 8'h04
`define ESIO_OFF_RANGE 8'h08
`define ESIO_OFF_OUT 8'h0C
`define ESIO_OFF_STATUS 8'h10
`define ESIO_OFF_EVENT 8'h14
`define ESIO_OFF_CMD 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ESIO_CTRL_AUTOFN 1:0
`define ESIO_CTRL_CLASS 3:2
`define ESIO_CTRL_STYPE 5:4
`define ESIO_CTRL_RELACT 8:6
`define ESIO_CTRL_AUTORUN 9
`define ESIO_CTRL_DRVREC 10
`define ESIO_CTRL_PCANFN 11
`define ESIO_CTRL_SRSTFN 12
`define ESIO_PROG_EMERG 7:0
`define ESIO_PROG_EXEC 15:8
`define ESIO_RANGE_LO 8:0
`define ESIO_RANGE_HI 24:16
`define ESIO_CMD_DRVON 0
`define ESIO_CMD_EDONE 1
`define ESIO_EV_REFUSED 0
`define ESIO_EV_RESUMED 1
`define ESIO_EV_SRST 2
`define ESIO_EV_ERST 3

// ----------------------------------------------------------------
// Reset values and setting codes
// ----------------------------------------------------------------
`define ESIO_CTRL_RST 32'h00000000
`define ESIO_PROG_RST 32'h00000000
`define ESIO_RANGE_RST 32'h00000000
`define ESIO_OUT_RST 32'h00000000
`define ESIO_AUTOFN_ON 2'h2
`define ESIO_CLASS_RUN 2'h0
`define ESIO_STYPE_RUN_OR_CAN 2'h0
`define ESIO_STYPE_CAN 2'h1
`define ESIO_STYPE_ERR_RUN 2'h2
`define ESIO_STYPE_ERR 2'h3
`define ESIO_REL_RESUME 3'h2
`define ESIO_REL_SRST 3'h3
`define ESIO_REL_ERST 3'h4

// ----------------------------------------------------------------
// Port numbers and timing
// ----------------------------------------------------------------
`define ESIO_OUT_BASE 300
`define ESIO_OUT_COUNT 24
`define ESIO_AUTO_PORT 319
`define ESIO_IN_COUNT 32
`define ESIO_IN_PCAN 21
`define ESIO_IN_SRST 17
`define ESIO_CLK_MHZ 100
`define ESIO_SRST_HOLD_MS 1000
`define ESIO_SRST_HOLD_CYCLES (`ESIO_SRST_HOLD_MS * 1000 * `ESIO_CLK_MHZ)

`endif

// *** hw/esio_supervisor.v ***
`timescale 1ns/1ps
`include "esio_consts.vh"
module esio_supervisor #(
    parameter AW = 8,
    parameter NOUT = `ESIO_OUT_COUNT,
    parameter NIN = `ESIO_IN_COUNT,
    parameter [31:0] HOLD_CYCLES = `ESIO_SRST_HOLD_CYCLES
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Discrete pins
    input wire [NIN-1:0] din_in,
    input wire estop_in,
    input wire gate_open_in,
    output reg [NOUT-1:0] dout_r,
    // Controller status, same clock
    input wire prog_running,
    input wire mode_auto,
    input wire err_op_level,
    input wire all_cancel,
    input wire emerg_prog_motion,
    // Controller commands
    output reg prog_start_r,
    output reg [7:0] prog_num_r,
    output reg soft_reset_r,
    output reg err_reset_r,
    output reg resume_r,
    output reg pause_cancel_r,
    output reg drive_en_r,
    output reg emerg_run_r,
    output reg auto_op_r
);
    localparam [AW-1:0] A_CTRL = `ESIO_OFF_CTRL;
    localparam [AW-1:0] A_PROG = `ESIO_OFF_PROG;
    localparam [AW-1:0] A_RANGE = `ESIO_OFF_RANGE;
    localparam [AW-1:0] A_OUT = `ESIO_OFF_OUT;
    localparam [AW-1:0] A_STATUS = `ESIO_OFF_STATUS;
    localparam [AW-1:0] A_EVENT = `ESIO_OFF_EVENT;
    localparam [AW-1:0] A_CMD = `ESIO_OFF_CMD;
    localparam [1:0] RESP_OK = 2'h0;
    localparam [1:0] RESP_ERR = 2'h2;
    localparam integer AUTO_IDX = `ESIO_AUTO_PORT - `ESIO_OUT_BASE;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    function mapped;
        input [AW-1:0] a;
        begin
            mapped = (a == A_CTRL) || (a == A_PROG) || (a == A_RANGE) || (a == A_OUT) ||
                     (a == A_STATUS) || (a == A_EVENT) || (a == A_CMD);
        end
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers and edges
    // ----------------------------------------------------------------
    wire [NIN+1:0] pins_s;
    reg [NIN-1:0] din_prev_r;
    reg stop_prev_r;
    reg cancel_prev_r;

    esio_sync #(.W(NIN + 2)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d_in({gate_open_in, estop_in, din_in}),
        .q_r(pins_s)
    );

    wire [NIN-1:0] din_s = pins_s[NIN-1:0];
    wire estop_s = pins_s[NIN];
    wire gate_s = pins_s[NIN+1];
    wire stop_act = estop_s | gate_s;
    wire stop_rise = stop_act & ~stop_prev_r;
    wire stop_fall = ~stop_act & stop_prev_r;
    wire [NIN-1:0] din_rise = din_s & ~din_prev_r;
    wire cancel_evt = stop_rise | (all_cancel & ~cancel_prev_r);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [31:0] ctrl_r;
    reg [31:0] prog_r;
    reg [31:0] range_r;
    reg [31:0] out_sw_r;
    reg [3:0] event_r;
    reg [AW-1:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_have_r;
    reg was_auto_r;
    reg resume_arm_r;
    reg autorun_pend_r;
    reg [31:0] hold_cnt_r;

    wire [1:0] autofn = ctrl_r[`ESIO_CTRL_AUTOFN];
    wire [1:0] aclass = ctrl_r[`ESIO_CTRL_CLASS];
    wire [1:0] stype = ctrl_r[`ESIO_CTRL_STYPE];
    wire [2:0] relact = ctrl_r[`ESIO_CTRL_RELACT];
    wire autorun = ctrl_r[`ESIO_CTRL_AUTORUN];
    wire drvrec = ctrl_r[`ESIO_CTRL_DRVREC];
    wire pcanfn = ctrl_r[`ESIO_CTRL_PCANFN];
    wire srstfn = ctrl_r[`ESIO_CTRL_SRSTFN];
    wire [8:0] rng_lo = range_r[`ESIO_RANGE_LO];
    wire [8:0] rng_hi = range_r[`ESIO_RANGE_HI];

    wire wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire [31:0] wr_m = merge(32'h00000000, w_data_r, w_strb_r);
    wire wr_cmd = wr_fire && (aw_addr_r == A_CMD);

    // ----------------------------------------------------------------
    // Decisions
    // ----------------------------------------------------------------
    reg [NOUT-1:0] in_rng;
    reg emerg_cond;
    integer i;
    integer j;

    always @* begin
        for (i = 0; i < NOUT; i = i + 1) begin
            in_rng[i] = ((`ESIO_OUT_BASE + i) >= rng_lo) && ((`ESIO_OUT_BASE + i) <= rng_hi);
        end
    end

    always @* begin
        emerg_cond = 1'b0;
        case (stype)
            `ESIO_STYPE_RUN_OR_CAN: emerg_cond = prog_running | cancel_evt;
            `ESIO_STYPE_CAN: emerg_cond = cancel_evt;
            `ESIO_STYPE_ERR_RUN: emerg_cond = err_op_level & cancel_evt & prog_running;
            `ESIO_STYPE_ERR: emerg_cond = err_op_level & cancel_evt;
            default: emerg_cond = 1'b0;
        endcase
    end

    // Start is only considered at a cancellation event, also for type 0
    wire emerg_try = cancel_evt & emerg_cond & ~emerg_run_r;
    wire emerg_ok = emerg_try & ~emerg_prog_motion;
    wire emerg_ref = emerg_try & emerg_prog_motion;
    wire auto_now = (aclass == `ESIO_CLASS_RUN) ? prog_running : (prog_running & mode_auto);
    wire hold_fire = srstfn && din_s[`ESIO_IN_SRST] && (hold_cnt_r == HOLD_CYCLES - 32'h1);
    wire srst_now = (stop_fall && (relact == `ESIO_REL_SRST)) | hold_fire;
    wire erst_now = stop_fall && (relact == `ESIO_REL_ERST);
    wire pcan_rise = pcanfn & din_rise[`ESIO_IN_PCAN] & ~stop_act;
    wire resume_now = pcan_rise & resume_arm_r;

    // ----------------------------------------------------------------
    // AXI4-Lite slave and register file
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
            aw_addr_r <= {AW{1'b0}};
            aw_have_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            w_have_r <= 1'b0;
            ctrl_r <= `ESIO_CTRL_RST;
            prog_r <= `ESIO_PROG_RST;
            range_r <= `ESIO_RANGE_RST;
            out_sw_r <= `ESIO_OUT_RST;
            event_r <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_r) ? RESP_OK : RESP_ERR;
                if (aw_addr_r == A_CTRL) begin
                    ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
                end
                if (aw_addr_r == A_PROG) begin
                    prog_r <= merge(prog_r, w_data_r, w_strb_r);
                end
                if (aw_addr_r == A_RANGE) begin
                    range_r <= merge(range_r, w_data_r, w_strb_r);
                end
                if (aw_addr_r == A_OUT) begin
                    out_sw_r <= merge(out_sw_r, w_data_r, w_strb_r);
                end
            end
            // Set wins over a write-one-to-clear in the same cycle
            event_r <= (event_r & ~((wr_fire && (aw_addr_r == A_EVENT)) ? wr_m[3:0] : 4'h0)) |
                       {erst_now, srst_now, resume_now, emerg_ref};
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OK;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
                case (s_axi_araddr)
                    A_CTRL: s_axi_rdata <= ctrl_r;
                    A_PROG: s_axi_rdata <= prog_r;
                    A_RANGE: s_axi_rdata <= range_r;
                    A_OUT: s_axi_rdata <= out_sw_r;
                    A_STATUS: s_axi_rdata <= {24'h000000, was_auto_r, auto_op_r, resume_arm_r, drive_en_r,
                                              emerg_run_r, gate_s, estop_s, stop_act};
                    A_EVENT: s_axi_rdata <= {28'h0000000, event_r};
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Supervisor state
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            din_prev_r <= {NIN{1'b0}};
            stop_prev_r <= 1'b0;
            cancel_prev_r <= 1'b0;
            was_auto_r <= 1'b0;
            resume_arm_r <= 1'b0;
            autorun_pend_r <= 1'b0;
            hold_cnt_r <= 32'h00000000;
            emerg_run_r <= 1'b0;
            drive_en_r <= 1'b0;
            auto_op_r <= 1'b0;
            prog_start_r <= 1'b0;
            prog_num_r <= 8'h00;
            soft_reset_r <= 1'b0;
            err_reset_r <= 1'b0;
            resume_r <= 1'b0;
            pause_cancel_r <= 1'b0;
            dout_r <= {NOUT{1'b0}};
        end else begin
            din_prev_r <= din_s;
            stop_prev_r <= stop_act;
            cancel_prev_r <= all_cancel;
            auto_op_r <= auto_now;
            soft_reset_r <= srst_now;
            err_reset_r <= erst_now;
            resume_r <= resume_now;
            pause_cancel_r <= pcan_rise & ~resume_arm_r;
            prog_start_r <= 1'b0;
            // Hold counter saturates so one long press gives one reset
            if (srstfn && din_s[`ESIO_IN_SRST]) begin
                if (hold_cnt_r != HOLD_CYCLES) begin
                    hold_cnt_r <= hold_cnt_r + 32'h1;
                end
            end else begin
                hold_cnt_r <= 32'h00000000;
            end
            if (stop_rise) begin
                was_auto_r <= auto_op_r;
                resume_arm_r <= 1'b0;
                drive_en_r <= 1'b0;
            end else if (stop_fall) begin
                emerg_run_r <= 1'b0;
                resume_arm_r <= (relact == `ESIO_REL_RESUME) & was_auto_r;
                if (!drvrec) begin
                    drive_en_r <= 1'b1;
                end
            end else if (resume_now) begin
                resume_arm_r <= 1'b0;
            end
            if (wr_cmd && wr_m[`ESIO_CMD_DRVON] && !stop_act) begin
                drive_en_r <= 1'b1;
            end
            if (wr_cmd && wr_m[`ESIO_CMD_EDONE]) begin
                emerg_run_r <= 1'b0;
            end
            if (srst_now | erst_now) begin
                autorun_pend_r <= 1'b1;
            end else if (autorun_pend_r) begin
                autorun_pend_r <= 1'b0;
            end
            if (emerg_ok) begin
                emerg_run_r <= 1'b1;
                prog_start_r <= 1'b1;
                prog_num_r <= prog_r[`ESIO_PROG_EMERG];
            end else if (autorun_pend_r && autorun && mode_auto && !stop_act) begin
                prog_start_r <= 1'b1;
                prog_num_r <= prog_r[`ESIO_PROG_EXEC];
            end
            for (j = 0; j < NOUT; j = j + 1) begin
                if (stop_act && in_rng[j]) begin
                    if (emerg_run_r) begin
                        dout_r[j] <= out_sw_r[j];
                    end
                end else if (stop_act) begin
                    dout_r[j] <= 1'b0;
                end else if ((j == AUTO_IDX) && (autofn == `ESIO_AUTOFN_ON)) begin
                    dout_r[j] <= auto_now;
                end else begin
                    dout_r[j] <= out_sw_r[j];
                end
            end
        end
    end
endmodule // esio_supervisor

// *** hw/esio_sync.v ***
`timescale 1ns/1ps
module esio_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Data
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_r
);
    reg [W-1:0] meta_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= {W{1'b0}};
            q_r <= {W{1'b0}};
        end else begin
            meta_r <= d_in;
            q_r <= meta_r;
        end
    end
endmodule // esio_sync

// *** test/esio_partner.sv ***
`timescale 1ns/1ps
module esio_partner (
    // Clock
    input wire aclk,
    // Switches
    output reg estop_in,
    output reg gate_open_in,
    output reg [31:0] din_in
);
    initial begin
        estop_in = 1'b0;
        gate_open_in = 1'b0;
        din_in = 32'h00000000;
    end
    task automatic set_stop(input reg e, input reg g);
        estop_in <= e;
        gate_open_in <= g;
        repeat (8) @(posedge aclk);
    endtask
    // Switch press; any input only while no stop or open gate is active
    task automatic press(input integer b, input integer cyc);
        if (!estop_in && !gate_open_in) din_in[b] <= 1'b1;
        repeat (cyc) @(posedge aclk);
        din_in[b] <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
endmodule // esio_partner

// *** test/esio_sva.sv ***
`timescale 1ns/1ps
`include "esio_consts.vh"
module esio_sva #(
    parameter NOUT = 24,
    parameter NIN = 32,
    parameter [31:0] HOLD_CYCLES = 20
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Pins
    input wire [NIN-1:0] din_in,
    input wire estop_in,
    input wire gate_open_in,
    input wire [NOUT-1:0] dout_r,
    // Controller side
    input wire prog_running,
    input wire emerg_prog_motion,
    input wire prog_start_r,
    input wire soft_reset_r,
    input wire err_reset_r,
    input wire resume_r,
    input wire pause_cancel_r,
    input wire drive_en_r,
    input wire emerg_run_r,
    input wire auto_op_r
);
    reg [31:0] hold_cnt_r;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Raw high time of the soft-reset pin
    always @(posedge aclk) begin
        if (!aresetn || !din_in[`ESIO_IN_SRST]) begin
            hold_cnt_r <= 32'h00000000;
        end else begin
            hold_cnt_r <= hold_cnt_r + 32'h00000001;
        end
    end
    a_auto_needs_run: assert property (
        !prog_running |=> !auto_op_r) else $error("auto flag without running program");
    a_emerg_with_start: assert property (
        $rose(emerg_run_r) |-> prog_start_r) else $error("emergency run without start pulse");
    a_motion_refused: assert property (
        emerg_prog_motion |=> !$rose(emerg_run_r)) else $error("motion program started");
    a_hold_outputs: assert property (
        estop_in && $past(estop_in, 6) && !emerg_run_r && !$past(emerg_run_r) |-> $stable(dout_r))
        else $error("outputs moved during stop");
    a_drive_cut: assert property (
        $rose(estop_in) |-> ##[1:6] !drive_en_r) else $error("drive not cut on stop");
    a_resume_clear: assert property (
        resume_r |-> !estop_in && !gate_open_in) else $error("resume during stop");
    a_pause_alone: assert property (
        pause_cancel_r |-> !resume_r && !estop_in) else $error("pause cancel clash");
    a_soft_single: assert property (
        soft_reset_r |=> !soft_reset_r) else $error("soft reset not a single pulse");
    a_err_single: assert property (
        err_reset_r |=> !err_reset_r [*3]) else $error("error reset repeated");
    a_soft_hold: assert property (
        soft_reset_r && din_in[`ESIO_IN_SRST] |-> hold_cnt_r >= HOLD_CYCLES) else $error("soft reset too early");
endmodule // esio_sva
bind esio_supervisor esio_sva #(
    .NOUT(NOUT),
    .NIN(NIN),
    .HOLD_CYCLES(HOLD_CYCLES)
) u_sva (
    .aclk(aclk), .aresetn(aresetn), .din_in(din_in), .estop_in(estop_in), .gate_open_in(gate_open_in),
    .dout_r(dout_r), .prog_running(prog_running), .emerg_prog_motion(emerg_prog_motion),
    .prog_start_r(prog_start_r), .soft_reset_r(soft_reset_r), .err_reset_r(err_reset_r), .resume_r(resume_r),
    .pause_cancel_r(pause_cancel_r), .drive_en_r(drive_en_r), .emerg_run_r(emerg_run_r), .auto_op_r(auto_op_r)
);

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "esio_consts.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, a, e); end end
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic prog_running = 1'b0, mode_auto = 1'b0, err_op_level = 1'b0, all_cancel = 1'b0, emerg_prog_motion = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, estop_in, gate_open_in;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, din_in;
    wire [23:0] dout_r;
    wire [7:0] prog_num_r;
    wire prog_start_r, soft_reset_r, err_reset_r, resume_r, pause_cancel_r, drive_en_r, emerg_run_r, auto_op_r;
    integer err_total = 0, num_checks = 0, i;
    integer cnt[5] = '{0, 0, 0, 0, 0};
    integer base[5] = '{0, 0, 0, 0, 0};
    reg [7:0] last_num = 8'h00;
    reg [5:0] tbl [8] = '{6'h01, 6'h11, 6'h28, 6'h24, 6'h2D, 6'h35, 6'h30, 6'h12};

    esio_supervisor #(.HOLD_CYCLES(32'd20)) DUT (.*);
    esio_partner u_sw (.*);

    initial forever #5 aclk = ~aclk;
    // Pulse tally: start, soft reset, error reset, resume, pause cancel
    always @(posedge aclk) begin
        cnt[0] <= cnt[0] + (prog_start_r === 1'b1);
        cnt[1] <= cnt[1] + (soft_reset_r === 1'b1);
        cnt[2] <= cnt[2] + (err_reset_r === 1'b1);
        cnt[3] <= cnt[3] + (resume_r === 1'b1);
        cnt[4] <= cnt[4] + (pause_cancel_r === 1'b1);
        if (prog_start_r === 1'b1) last_num <= prog_num_r;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tmo;
        err_total++;
        $display("MISMATCH %0t wait ran out", $time);
        summarize;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
        integer n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        if (s_axi_bvalid !== 1'b1) tmo;
        `CHK(s_axi_bresp, er)
        // One edge between transfers keeps bready from two writes in one step
        @(posedge aclk);
    endtask
    task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        integer n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        if (s_axi_rvalid !== 1'b1) tmo;
        `CHK(s_axi_rdata, ed)
        `CHK(s_axi_rresp, er)
        @(posedge aclk);
    endtask
    // Waits for n pulses of kind k, then lets late extras show
    task automatic expc(input integer k, input integer n);
        integer w;
        for (w = 0; w < 40 && cnt[k] - base[k] < n; w++) @(posedge aclk);
        if (w == 40) tmo;
        repeat (10) @(posedge aclk);
        `CHK(cnt[k] - base[k], n)
        base[k] = cnt[k];
    endtask
    function automatic [31:0] ctl(input [1:0] af, input [1:0] cl, input [1:0] st, input [2:0] ra, input [3:0] fl);
        ctl = {19'h0, fl, ra, st, cl, af};
    endfunction

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ESIO_OFF_CTRL, 32'h0, 2'h0);
        rd(`ESIO_OFF_RANGE, 32'h0, 2'h0);
        rd(8'h1C, 32'h0, 2'h2);
        wr(8'h1C, 32'hFFFFFFFF, 2'h2);
        wr(`ESIO_OFF_CTRL, ctl(2'h2, 2'h0, 2'h0, 3'h0, 4'h0), 2'h0);
        prog_running <= 1'b1;
        repeat (6) @(posedge aclk);
        `CHK(dout_r[19], 1'b1)
        wr(`ESIO_OFF_CTRL, ctl(2'h2, 2'h1, 2'h0, 3'h0, 4'h0), 2'h0);
        repeat (6) @(posedge aclk);
        `CHK(auto_op_r, 1'b0)
        prog_running <= 1'b0;
        wr(`ESIO_OFF_RANGE, 32'h01330130, 2'h0);
        wr(`ESIO_OFF_PROG, 32'h00000905, 2'h0);
        wr(`ESIO_OFF_OUT, 32'h000001F8, 2'h0);
        wr(`ESIO_OFF_CTRL, ctl(2'h0, 2'h0, 2'h1, 3'h3, 4'h1), 2'h0);
        wr(`ESIO_OFF_CMD, 32'h1, 2'h0);
        mode_auto <= 1'b1;
        `CHK(dout_r, 24'h0001F8)
        u_sw.set_stop(1'b1, 1'b0);
        expc(0, 1);
        `CHK(last_num, 8'h05)
        `CHK(dout_r, 24'h0000F0)
        `CHK(drive_en_r, 1'b0)
        wr(`ESIO_OFF_OUT, 32'h0, 2'h0);
        wr(`ESIO_OFF_CMD, 32'h1, 2'h0);
        `CHK(dout_r, 24'h0)
        `CHK(drive_en_r, 1'b0)
        wr(`ESIO_OFF_CMD, 32'h2, 2'h0);
        u_sw.set_stop(1'b0, 1'b0);
        expc(1, 1);
        expc(0, 1);
        `CHK(last_num, 8'h09)
        `CHK(drive_en_r, 1'b1)
        rd(`ESIO_OFF_EVENT, 32'h4, 2'h0);
        wr(`ESIO_OFF_EVENT, 32'hF, 2'h0);
        for (i = 0; i < 8; i++) begin
            wr(`ESIO_OFF_CTRL, ctl(2'h0, 2'h0, tbl[i][5:4], 3'h0, 4'h0), 2'h0);
            prog_running <= tbl[i][3];
            err_op_level <= tbl[i][2];
            emerg_prog_motion <= tbl[i][1];
            repeat (2) @(posedge aclk);
            all_cancel <= 1'b1;
            expc(0, tbl[i][0]);
            all_cancel <= 1'b0;
            wr(`ESIO_OFF_CMD, 32'h2, 2'h0);
        end
        emerg_prog_motion <= 1'b0;
        rd(`ESIO_OFF_EVENT, 32'h1, 2'h0);
        wr(`ESIO_OFF_CTRL, ctl(2'h0, 2'h0, 2'h2, 3'h4, 4'h3), 2'h0);
        wr(`ESIO_OFF_OUT, 32'h000000F0, 2'h0);
        prog_running <= 1'b0;
        err_op_level <= 1'b0;
        u_sw.set_stop(1'b0, 1'b1);
        wr(`ESIO_OFF_OUT, 32'h0, 2'h0);
        `CHK(dout_r, 24'h0000F0)
        u_sw.set_stop(1'b0, 1'b0);
        expc(2, 1);
        expc(0, 1);
        `CHK(last_num, 8'h09)
        `CHK(drive_en_r, 1'b0)
        wr(`ESIO_OFF_CTRL, ctl(2'h0, 2'h0, 2'h2, 3'h2, 4'h4), 2'h0);
        prog_running <= 1'b1;
        u_sw.set_stop(1'b1, 1'b0);
        u_sw.set_stop(1'b0, 1'b0);
        u_sw.press(`ESIO_IN_PCAN, 3);
        expc(3, 1);
        prog_running <= 1'b0;
        u_sw.set_stop(1'b1, 1'b0);
        u_sw.set_stop(1'b0, 1'b0);
        u_sw.press(`ESIO_IN_PCAN, 3);
        expc(4, 1);
        expc(3, 0);
        wr(`ESIO_OFF_CTRL, ctl(2'h0, 2'h0, 2'h2, 3'h0, 4'h8), 2'h0);
        u_sw.press(`ESIO_IN_SRST, 15);
        expc(1, 0);
        u_sw.press(`ESIO_IN_SRST, 30);
        expc(1, 1);
        wr(`ESIO_OFF_CTRL, 32'h0, 2'h0);
        u_sw.press(`ESIO_IN_SRST, 30);
        expc(1, 0);
        summarize;
    end
endmodule // tb_top
